//--- hdl/burst_sram_pkg.sv
// Shared widths, reset values, pin bundles and read sequencer states of the burst SRAM port
package burst_sram_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W        = 6;   // Burst address width (two words per burst)
  localparam int DATA_W        = 36;  // Widest word organisation
  localparam int MASK_W        = 4;   // Widest lane mask
  localparam int LANE_W_WIDE   = 9;   // Lane width in the 18 and 36 bit organisations
  localparam int LANE_W_NIBBLE = 4;   // Lane width in the 8 bit organisation
  localparam int ORG_X8        = 8;   // Word widths of the three organisations
  localparam int ORG_X18       = 18;
  localparam int ORG_X36       = 36;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] READ_DATA_RESET = 36'h0;
  localparam logic              READ_OE_N_RESET = 1'b1;  // Outputs released
  localparam logic              ECHO_RESET      = 1'b0;
  localparam logic              SINGLE_RESET    = 1'b0;

  // ----------------------------------------------------------------------
  // Bundles
  // ----------------------------------------------------------------------
  // One sample of every pin the controller drives
  typedef struct packed {
    logic              k_pos;
    logic              k_neg;
    logic              c_pos;
    logic              c_neg;
    logic              load_n;
    logic              read_not_write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [MASK_W-1:0] mask_n;
  } pin_sample_t;

  // A complete write burst held back until the next write
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] d0;
    logic [MASK_W-1:0] m0;
    logic [DATA_W-1:0] d1;
    logic [MASK_W-1:0] m1;
  } posted_write_t;

  // Read sequencer states, one-hot
  typedef enum logic [4:0] {
    RD_IDLE   = 5'h01,
    RD_ARM    = 5'h02,
    RD_FIRST  = 5'h04,
    RD_SECOND = 5'h08,
    RD_DRAIN  = 5'h10
  } read_state_t;

endpackage

//--- hdl/lane_merge.sv
// Per-lane write mask merge of one burst word into the stored word
`timescale 1ns/1ps
`default_nettype none

module lane_merge #(
  parameter int ORG_BITS = burst_sram_pkg::ORG_X36
) (
  input  wire logic [burst_sram_pkg::DATA_W-1:0] old_word_in,
  input  wire logic [burst_sram_pkg::DATA_W-1:0] new_word_in,
  input  wire logic [burst_sram_pkg::MASK_W-1:0] mask_n_in,
  output logic      [burst_sram_pkg::DATA_W-1:0] merged_out
);

  // ----------------------------------------------------------------------
  // Bit selection
  // ----------------------------------------------------------------------
  // Each bit picks its lane from the organisation; bits above the word
  // width always keep the stored value so narrow parts never touch them
  for (genvar i = 0; i < burst_sram_pkg::DATA_W; i++) begin : g_bit
    localparam int LANE = (ORG_BITS == burst_sram_pkg::ORG_X8) ?
                          i / burst_sram_pkg::LANE_W_NIBBLE :
                          i / burst_sram_pkg::LANE_W_WIDE;
    if (i < ORG_BITS) begin : g_used
      // Low mask bit stores the lane, high leaves it unaltered; all low is the
      // whole word, all high is nothing (see RL8, RL9, RL10, RL11, RL12, RL13, RL14)
      assign merged_out[i] = mask_n_in[LANE] ? old_word_in[i] : new_word_in[i];
    end else begin : g_unused
      assign merged_out[i] = old_word_in[i];
    end
  end

endmodule

`default_nettype wire

//--- hdl/burst_sram_port.sv
// Command, posted write and double rate read logic of a two-word burst SRAM
//
// Overview of operation
// RL1 - Low load, low select starts write burst
// RL2 - Read words at output neg t+1, pos t+2
// RL3 - Power up deselected with outputs released
// RL4 - Burst order is offset zero then one
// RL5 - Write words taken on both input rises
// RL6 - Read edges from output clocks, else input
// RL7 - Stopped clocks preferably parked equal and high; the bench parks K and K# equal but low
// RL8 - All masks low store the whole word
// RL9 - Mask bit zero governs bits 8..0
// RL10 - Mask bit one governs bits 17..9
// RL11 - Narrow part: nibble lanes 3..0, 7..4
// RL12 - Wide part: bits 17..9 and 26..18
// RL13 - Mask bit three governs bits 35..27
// RL14 - All masks high store nothing
// RL15 - Masks sampled separately with each word
// RL16 - Deselect: finish reads, release after pos rise
// RL17 - Both output clocks high at start: single mode
// RL18 - Write held in registers until next write
// RL19 - Stopped clocks keep outputs, start nothing
// RL20 - High load starts no transaction
`timescale 1ns/1ps
`default_nettype none

module burst_sram_port #(
  parameter int ORG_BITS = burst_sram_pkg::ORG_X36  // Word organisation: 8, 18 or 36
) (
  input  wire logic                              ref_clk_in,
  input  wire logic                              rst_in,
  input  wire logic                              k_pos_in,
  input  wire logic                              k_neg_in,
  input  wire logic                              c_pos_in,
  input  wire logic                              c_neg_in,
  input  wire logic                              load_n_in,
  input  wire logic                              read_not_write_in,
  input  wire logic [burst_sram_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [burst_sram_pkg::DATA_W-1:0] write_data_in,
  input  wire logic [burst_sram_pkg::MASK_W-1:0] lane_write_mask_n_in,
  output logic      [burst_sram_pkg::DATA_W-1:0] read_data_out,
  output logic                                   read_oe_n_out,
  output logic                                   echo_timing_out
);

  localparam int WORDS = 2 ** (burst_sram_pkg::ADDR_W + 1);  // Two words per burst address

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  burst_sram_pkg::pin_sample_t pins;      // Raw pin bundle
  burst_sram_pkg::pin_sample_t meta;      // First stage, read only by the second
  burst_sram_pkg::pin_sample_t smp;       // Settled sample
  burst_sram_pkg::pin_sample_t prev;      // Settled sample one cycle older

  assign pins = '{k_pos: k_pos_in, k_neg: k_neg_in, c_pos: c_pos_in, c_neg: c_neg_in,
                  load_n: load_n_in, read_not_write: read_not_write_in, addr: addr_in,
                  wdata: write_data_in, mask_n: lane_write_mask_n_in};

  // No reset here: the strap must see the true pins right at release
  always_ff @(posedge ref_clk_in) begin
    meta <= pins;
    smp  <= meta;
    prev <= smp;
  end

  // ----------------------------------------------------------------------
  // Clock strap and edge detection
  // ----------------------------------------------------------------------
  logic single_mode;  // Input clocks also time the outputs
  logic strap_done;   // Strap has been taken

  // Strap is caught once, in the first cycle after reset, then frozen
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      single_mode <= burst_sram_pkg::SINGLE_RESET;
      strap_done  <= 1'b0;
    end else if (!strap_done) begin
      single_mode <= smp.c_pos & smp.c_neg;  // see RL17
      strap_done  <= 1'b1;
    end
  end

  wire k_rise        = smp.k_pos & ~prev.k_pos;   // Positive input clock rise
  wire kn_rise       = smp.k_neg & ~prev.k_neg;   // Negative input clock rise
  wire c_rise        = smp.c_pos & ~prev.c_pos;
  wire cn_rise       = smp.c_neg & ~prev.c_neg;
  // Output timing edges follow the strap (see RL6)
  wire out_pos_rise  = single_mode ? k_rise  : c_rise;
  wire out_neg_rise  = single_mode ? kn_rise : cn_rise;
  // Only a low load at a positive rise starts anything (see RL20, RL19)
  wire read_start    = k_rise & ~smp.load_n & smp.read_not_write;
  wire write_start   = k_rise & ~smp.load_n & ~smp.read_not_write;  // see RL1

  // ----------------------------------------------------------------------
  // Storage and posted write
  // ----------------------------------------------------------------------
  logic [burst_sram_pkg::DATA_W-1:0] mem [0:WORDS-1];     // Array, word addressed
  burst_sram_pkg::posted_write_t     pend;                // Posted burst
  logic                              pend_valid;          // Posted burst waiting
  logic [burst_sram_pkg::ADDR_W-1:0] wr_addr;             // Address of latest write
  logic [burst_sram_pkg::ADDR_W-1:0] cap_addr;            // Address of burst in flight
  logic [burst_sram_pkg::DATA_W-1:0] cap_d0;              // First word in flight
  logic [burst_sram_pkg::MASK_W-1:0] cap_m0;              // Its own mask
  logic                              w0_due;              // First word due at next rise
  logic                              w1_due;              // Second word due at neg rise
  logic [burst_sram_pkg::DATA_W-1:0] merged0;             // Posted word 0 over array
  logic [burst_sram_pkg::DATA_W-1:0] merged1;             // Posted word 1 over array

  wire [burst_sram_pkg::ADDR_W:0] pend_idx0 = {pend.addr, 1'b0};  // see RL4
  wire [burst_sram_pkg::ADDR_W:0] pend_idx1 = {pend.addr, 1'b1};
  // A burst posting over a held one pushes the held one to the array (see RL18)
  wire                            commit    = pend_valid & (write_start | (kn_rise & w1_due));

  // Each word merges with its own mask (see RL15)
  lane_merge #(.ORG_BITS(ORG_BITS)) u_merge0 (
    .old_word_in (mem[pend_idx0]),
    .new_word_in (pend.d0),
    .mask_n_in   (pend.m0),
    .merged_out  (merged0)
  );

  lane_merge #(.ORG_BITS(ORG_BITS)) u_merge1 (
    .old_word_in (mem[pend_idx1]),
    .new_word_in (pend.d1),
    .mask_n_in   (pend.m1),
    .merged_out  (merged1)
  );

  // Write sequencing flags; a burst only posts once both words are in
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      w0_due     <= 1'b0;
      w1_due     <= 1'b0;
      pend_valid <= 1'b0;
    end else begin
      if (kn_rise && w1_due) begin
        w1_due     <= 1'b0;
        pend_valid <= 1'b1;              // Setting wins over a commit
      end else if (commit) begin
        pend_valid <= 1'b0;              // see RL18
      end
      if (k_rise) begin
        w0_due <= write_start;
        if (w0_due) begin
          w1_due <= 1'b1;
        end
      end
    end
  end

  // Write data path: word 0 at the positive rise after the command,
  // word 1 at the following negative rise (see RL5)
  always_ff @(posedge ref_clk_in) begin
    if (write_start) begin
      wr_addr <= smp.addr;
    end
    if (k_rise && w0_due) begin
      cap_addr <= wr_addr;
      cap_d0   <= smp.wdata;
      cap_m0   <= smp.mask_n;
    end
    if (kn_rise && w1_due) begin
      pend <= '{addr: cap_addr, d0: cap_d0, m0: cap_m0, d1: smp.wdata, m1: smp.mask_n};
    end
  end

  // Array update: the posted burst lands when the next write starts or posts over it,
  // so a read in between never collides with the array write
  always_ff @(posedge ref_clk_in) begin
    if (commit) begin
      mem[pend_idx0] <= merged0;  // see RL18
      mem[pend_idx1] <= merged1;
    end
  end

  // ----------------------------------------------------------------------
  // Read sequencer
  // ----------------------------------------------------------------------
  burst_sram_pkg::read_state_t       rd_state;       // Current state
  burst_sram_pkg::read_state_t       next_rd_state;
  logic [burst_sram_pkg::ADDR_W-1:0] cur_addr;       // Burst being read
  logic [burst_sram_pkg::ADDR_W-1:0] next_cur_addr;
  logic [burst_sram_pkg::ADDR_W-1:0] q_addr;         // Read waiting behind it
  logic [burst_sram_pkg::ADDR_W-1:0] next_q_addr;
  logic                              q_valid;
  logic                              next_q_valid;
  logic [burst_sram_pkg::DATA_W-1:0] next_read_data;
  logic                              next_read_oe_n;
  logic                              took_direct;    // Start went straight to current

  // Reads see the posted burst, since it is not yet in the array
  wire                              hit_pend = pend_valid & (pend.addr == cur_addr);
  wire [burst_sram_pkg::DATA_W-1:0] rd_w0    = hit_pend ? merged0 : mem[{cur_addr, 1'b0}];
  wire [burst_sram_pkg::DATA_W-1:0] rd_w1    = hit_pend ? merged1 : mem[{cur_addr, 1'b1}];

  // Next state: arm on the command, first word at the negative output rise
  // of t+1, second word at the positive output rise of t+2
  always_comb begin
    next_rd_state  = rd_state;
    next_cur_addr  = cur_addr;
    next_q_addr    = q_addr;
    next_q_valid   = q_valid;
    next_read_data = read_data_out;
    next_read_oe_n = read_oe_n_out;
    took_direct    = 1'b0;
    case (rd_state)
      burst_sram_pkg::RD_IDLE: begin
        if (read_start) begin
          next_cur_addr = smp.addr;
          next_rd_state = burst_sram_pkg::RD_ARM;
          took_direct   = 1'b1;
        end
      end
      burst_sram_pkg::RD_ARM: begin
        // Wait for the positive output rise of t+1
        if (out_pos_rise) begin
          next_rd_state = burst_sram_pkg::RD_FIRST;
        end
      end
      burst_sram_pkg::RD_FIRST: begin
        if (out_neg_rise) begin
          next_read_data = rd_w0;  // see RL2, RL4
          next_read_oe_n = 1'b0;
          next_rd_state  = burst_sram_pkg::RD_SECOND;
        end
      end
      burst_sram_pkg::RD_SECOND, burst_sram_pkg::RD_DRAIN: begin
        if (out_pos_rise) begin
          if (rd_state == burst_sram_pkg::RD_SECOND) begin
            next_read_data = rd_w1;  // see RL2, RL4
            next_read_oe_n = 1'b0;
          end
          if (q_valid) begin
            // Back to back reads keep the outputs driven
            next_cur_addr = q_addr;
            next_q_valid  = 1'b0;
            next_rd_state = burst_sram_pkg::RD_FIRST;
          end else if (read_start) begin
            next_cur_addr = smp.addr;
            next_rd_state = burst_sram_pkg::RD_ARM;
            took_direct   = 1'b1;
          end else if (rd_state == burst_sram_pkg::RD_SECOND) begin
            next_rd_state = burst_sram_pkg::RD_DRAIN;
          end else begin
            next_read_oe_n = 1'b1;  // see RL16
            next_rd_state  = burst_sram_pkg::RD_IDLE;
          end
        end
      end
      default: begin
        next_rd_state = burst_sram_pkg::RD_IDLE;
      end
    endcase
    // A start that could not take the current slot waits one burst
    if (read_start && !took_direct) begin
      next_q_addr  = smp.addr;
      next_q_valid = 1'b1;
    end
  end

  // Sequencer registers; outputs come up released (see RL3)
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rd_state      <= burst_sram_pkg::RD_IDLE;
      q_valid       <= 1'b0;
      read_data_out <= burst_sram_pkg::READ_DATA_RESET;
      read_oe_n_out <= burst_sram_pkg::READ_OE_N_RESET;
    end else begin
      rd_state      <= next_rd_state;
      q_valid       <= next_q_valid;
      read_data_out <= next_read_data;
      read_oe_n_out <= next_read_oe_n;
    end
  end

  // Addresses carry no control meaning, so they skip reset
  always_ff @(posedge ref_clk_in) begin
    cur_addr <= next_cur_addr;
    q_addr   <= next_q_addr;
  end

  // ----------------------------------------------------------------------
  // Echo clock
  // ----------------------------------------------------------------------
  // Follows the output timing clock; a stopped clock freezes it (see RL19)
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      echo_timing_out <= burst_sram_pkg::ECHO_RESET;
    end else begin
      echo_timing_out <= single_mode ? smp.k_pos : smp.c_pos;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_deselect_reset;
    @(posedge ref_clk_in) $fell(rst_in) |-> read_oe_n_out && rd_state == burst_sram_pkg::RD_IDLE;
  endproperty
  a_deselect_reset: assert property (p_deselect_reset) else $error("outputs driven after reset"); // see RL3

  property p_first_word;
    @(posedge ref_clk_in) disable iff (rst_in)
      (rd_state == burst_sram_pkg::RD_FIRST && out_neg_rise) |=>
        !read_oe_n_out && read_data_out == $past(rd_w0) && rd_state == burst_sram_pkg::RD_SECOND;
  endproperty
  a_first_word: assert property (p_first_word) else $error("first read word not driven"); // see RL2

  property p_release;
    @(posedge ref_clk_in) disable iff (rst_in)
      (rd_state == burst_sram_pkg::RD_DRAIN && out_pos_rise && !q_valid && !read_start) |=>
        read_oe_n_out;
  endproperty
  a_release: assert property (p_release) else $error("outputs not released after drain"); // see RL16

  property p_no_start_load_high;
    @(posedge ref_clk_in) disable iff (rst_in)
      (k_rise && smp.load_n && rd_state == burst_sram_pkg::RD_IDLE) |=>
        rd_state == burst_sram_pkg::RD_IDLE && !w0_due;
  endproperty
  a_no_start_load_high: assert property (p_no_start_load_high) else $error("start with load high"); // see RL20

  property p_stopped_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
      (!k_rise && !kn_rise && !out_pos_rise && !out_neg_rise) |=>
        $stable(read_data_out) && $stable(read_oe_n_out) && $stable(pend_valid);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) else $error("state moved without a clock"); // see RL19

  property p_posted_commit;
    @(posedge ref_clk_in) disable iff (rst_in)
      (write_start && pend_valid && !kn_rise) |=> !pend_valid ##0 mem[$past(pend_idx0)] == $past(merged0);
  endproperty
  a_posted_commit: assert property (p_posted_commit) else $error("posted write not committed"); // see RL18

  property p_second_word;
    @(posedge ref_clk_in) disable iff (rst_in)
      (kn_rise && w1_due) |=> pend_valid && pend.d1 == $past(smp.wdata) && pend.d0 == $past(cap_d0);
  endproperty
  a_second_word: assert property (p_second_word) else $error("second write word lost"); // see RL5

  property p_write_cmd;
    @(posedge ref_clk_in) disable iff (rst_in)
      write_start |=> w0_due && wr_addr == $past(smp.addr);
  endproperty
  a_write_cmd: assert property (p_write_cmd) else $error("write command not taken"); // see RL1

  property p_masked_word;
    @(posedge ref_clk_in) disable iff (rst_in)
      (pend_valid && (&pend.m0)) |-> merged0 == mem[pend_idx0];
  endproperty
  a_masked_word: assert property (p_masked_word) else $error("fully masked word changed"); // see RL14

  property p_full_word;
    @(posedge ref_clk_in) disable iff (rst_in)
      (ORG_BITS == burst_sram_pkg::ORG_X36 && pend_valid && pend.m1 == 4'h0) |->
        merged1 == pend.d1;
  endproperty
  a_full_word: assert property (p_full_word) else $error("unmasked word not stored whole"); // see RL8

endmodule

`default_nettype wire

//--- testbench/sram_ctrl_model.sv
// Behavioural memory controller that clocks the burst SRAM port and records its read outputs
`timescale 1ns/1ps
`default_nettype none

module sram_ctrl_model (
  input  wire logic                              ref_clk_in,
  input  wire logic [burst_sram_pkg::DATA_W-1:0] read_data_in,
  input  wire logic                              read_oe_n_in,
  input  wire logic                              echo_in,
  output var  burst_sram_pkg::pin_sample_t       pins_out
);
  // ----------------------------------------------------------------------
  // Samples at beat 4 (mid) and beat 8 (late) of each eight-beat K cycle
  // ----------------------------------------------------------------------
  logic [burst_sram_pkg::DATA_W-1:0] q_mid     [64];
  logic [burst_sram_pkg::DATA_W-1:0] q_late    [64];
  logic                              oe_mid    [64];
  logic                              oe_late   [64];
  logic                              echo_mid  [64];
  logic                              echo_late [64];
  int                                n       = 0;     // K cycles issued
  logic                              wr_prev = 1'b0;  // Words of a write still due
  burst_sram_pkg::posted_write_t     pw;              // Words of that write
  logic                              single  = 1'b0;  // Holds C and C# high for the strap

  // C and C# mirror K and K# unless single is set or park holds them high, so the strap sees both high only then
  initial begin
    pins_out        = '0;
    pins_out.k_neg  = 1'b1;
    pins_out.c_neg  = 1'b1;
    pins_out.load_n = 1'b1;
    pins_out.mask_n = 4'hf;
  end

  // Pins change 1 ns after an edge, never on it
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic clocks(input logic p);
    pins_out.k_pos = p;
    pins_out.c_pos = p | single;
    pins_out.k_neg = !p;
    pins_out.c_neg = !p | single;
  endtask

  // Stopped clocks park K and K# equal and C and C# high
  task automatic park(input int c);
    pins_out.k_neg = 1'b0;
    pins_out.c_pos = 1'b1;
    pins_out.c_neg = 1'b1;
    tick(c);
  endtask

  // Idle data toggles so a stray capture never matches by luck
  task automatic word(input logic use_it, input logic [35:0] d, input logic [3:0] m);
    pins_out.wdata  = use_it ? d : ~pins_out.wdata;
    pins_out.mask_n = use_it ? m : 4'hf;
  endtask

  // One K cycle: command for this rise, words of the previous write on K and K#
  task automatic step(input logic ld_n, input logic rnw, input logic [5:0] a,
                      input logic [35:0] d0, input logic [35:0] d1,
                      input logic [3:0] m0, input logic [3:0] m1);
    if (n > 0) begin
      q_late[n-1]    = read_data_in;
      oe_late[n-1]   = read_oe_n_in;
      echo_late[n-1] = echo_in;
    end
    pins_out.load_n         = ld_n;
    pins_out.read_not_write = rnw;
    pins_out.addr           = a;
    word(wr_prev, pw.d0, pw.m0);
    tick(2);
    clocks(1'b1);
    tick(2);
    q_mid[n]    = read_data_in;
    oe_mid[n]   = read_oe_n_in;
    echo_mid[n] = echo_in;
    word(wr_prev, pw.d1, pw.m1);
    tick(2);
    clocks(1'b0);
    tick(2);
    wr_prev = !ld_n && !rnw;
    pw      = '{addr: a, d0: d0, m0: m0, d1: d1, m1: m1};
    n++;
  endtask
endmodule
`default_nettype wire

//--- testbench/burst_sram_port_tb.sv
// Self-checking bench of the burst SRAM port in the 36-bit organisation
`timescale 1ns/1ps
`default_nettype none

module burst_sram_port_tb;
  localparam logic [35:0] P0 = 36'h1_2345_6789;  // Burst patterns
  localparam logic [35:0] P1 = 36'he_dcba_9876;
  localparam logic [35:0] Q0 = 36'h3_c3c3_c3c3;
  localparam logic [35:0] Q1 = 36'h0_f0f0_f0f1;
  localparam logic [35:0] B  = 36'h9_6969_6969;  // Lane test base word

  logic                          ref_clk_in  = 1'b0;
  logic                          rst_in      = 1'b1;
  burst_sram_pkg::pin_sample_t   pins;
  logic [35:0]                   rdata;
  logic                          oe_n;
  logic                          echo;
  int                            n_errors    = 0;
  int                            checks_done = 0;
  int                            cycles      = 0;

  always #25 ref_clk_in = ~ref_clk_in;

  burst_sram_port DUT (
    .ref_clk_in           (ref_clk_in),
    .rst_in               (rst_in),
    .k_pos_in             (pins.k_pos),
    .k_neg_in             (pins.k_neg),
    .c_pos_in             (pins.c_pos),
    .c_neg_in             (pins.c_neg),
    .load_n_in            (pins.load_n),
    .read_not_write_in    (pins.read_not_write),
    .addr_in              (pins.addr),
    .write_data_in        (pins.wdata),
    .lane_write_mask_n_in (pins.mask_n),
    .read_data_out        (rdata),
    .read_oe_n_out        (oe_n),
    .echo_timing_out      (echo)
  );

  sram_ctrl_model u_ctrl (
    .ref_clk_in   (ref_clk_in),
    .read_data_in (rdata),
    .read_oe_n_in (oe_n),
    .echo_in      (echo),
    .pins_out     (pins)
  );

  // Hang guard: the tests need well under 1000 cycles
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk_word(input string what, input logic [35:0] exp, input logic [35:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Read issued in K cycle r: word0 at beat 4, word1 at beat 8 of cycle r+2
  task automatic chk_burst(input int r, input logic [35:0] e0, input logic [35:0] e1);
    chk_word("word0", e0, u_ctrl.q_mid[r+2]);
    chk_word("word1", e1, u_ctrl.q_late[r+2]);
    chk_bit("oe_n word0", 1'b0, u_ctrl.oe_mid[r+2]);
    chk_bit("oe_n word1", 1'b0, u_ctrl.oe_late[r+2]);
  endtask

  task automatic wr(input logic [5:0] a, input logic [35:0] d0, input logic [35:0] d1,
                    input logic [3:0] m0, input logic [3:0] m1);
    u_ctrl.step(1'b0, 1'b0, a, d0, d1, m0, m1);
  endtask

  task automatic rd_cmd(input logic [5:0] a);
    u_ctrl.step(1'b0, 1'b1, a, '0, '0, 4'hf, 4'hf);
  endtask

  // Deselect with either select level; the data handed in must never land
  task automatic nop(input logic rnw);
    u_ctrl.step(1'b1, rnw, 6'h05, 36'h0, 36'h0, 4'h0, 4'h0);
  endtask

  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] w,
                                        input logic [3:0] m);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (!m[i]) begin
        merge[9*i +: 9] = w[9*i +: 9];
      end
    end
  endfunction

  task automatic t_reset();
    chk_bit("oe_n at release", 1'b1, oe_n);
    chk_word("rdata at release", 36'h0, rdata);
    repeat (3) nop(1'b1);
    chk_bit("oe_n idle", 1'b1, u_ctrl.oe_mid[2]);
    chk_bit("echo high", 1'b1, u_ctrl.echo_late[1]);
    chk_bit("echo low", 1'b0, u_ctrl.echo_mid[2]);
    $display("test reset done");
  endtask

  task automatic t_write_read();
    int r;
    wr(6'h05, P0, P1, 4'h0, 4'h0);
    r = u_ctrl.n;
    rd_cmd(6'h05);
    nop(1'b0);
    wr(6'h06, Q0, Q1, 4'h0, 4'h0);
    rd_cmd(6'h05);
    repeat (5) nop(1'b1);
    chk_bit("oe_n early", 1'b1, u_ctrl.oe_mid[r+1]);
    chk_burst(r, P0, P1);
    chk_burst(r + 3, P0, P1);
    chk_bit("oe_n drained", 1'b1, u_ctrl.oe_late[r+6]);
    $display("test write_read done");
  endtask

  // One lane on word0, the mirrored lane on word1, then no lane at all
  task automatic t_lanes();
    int         r;
    logic [3:0] m0;
    logic [3:0] m1;
    for (int i = 0; i < 5; i++) begin
      m0 = (i < 4) ? ~(4'h1 << i) : 4'hf;
      m1 = (i < 4) ? ~(4'h8 >> i) : 4'hf;
      wr(6'h0a, B, B, 4'h0, 4'h0);
      wr(6'h0a, ~B, ~B, m0, m1);
      r = u_ctrl.n;
      rd_cmd(6'h0a);
      repeat (3) nop(1'b1);
      chk_burst(r, merge(B, ~B, m0), merge(B, ~B, m1));
    end
    $display("test lanes done");
  endtask

  task automatic t_stream();
    int r;
    r = u_ctrl.n;
    rd_cmd(6'h05);
    rd_cmd(6'h06);
    repeat (4) nop(1'b1);
    chk_burst(r, P0, P1);
    chk_burst(r + 1, Q0, Q1);
    chk_bit("oe_n after stream", 1'b1, u_ctrl.oe_late[r+4]);
    u_ctrl.park(16);
    chk_word("rdata stopped", Q1, rdata);
    chk_bit("oe_n stopped", 1'b1, oe_n);
    $display("test stream done");
  endtask

  // Output clocks held high through a reset: K and K# then time the reads
  task automatic t_single();
    int r;
    u_ctrl.single = 1'b1;
    rst_in = 1'b1;
    nop(1'b1);
    rst_in = 1'b0;
    r = u_ctrl.n;
    rd_cmd(6'h05);
    repeat (3) nop(1'b1);
    chk_burst(r, P0, P1);
    chk_bit("echo single", 1'b0, u_ctrl.echo_mid[r]);
    $display("test single done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge ref_clk_in);
    #1;
    rst_in = 1'b0;
    t_reset();
    t_write_read();
    t_lanes();
    t_stream();
    t_single();
    conclude();
  end
endmodule
`default_nettype wire
